// [rtl/rct_reset_cause_tracker.sv]
// reset cause tracker: source classification, domain reset scope, cause record
//
// Implementation choice: register access over AHB-Lite.
`default_nettype none

module rct_reset_cause_tracker #(
  parameter int HOLD_CYCLES = rct_pkg::RCT_HOLD_CYCLES_DEF
) (
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_b_i,
  // reset request sources
  input  wire logic                         core_supply_brownout_i,
  input  wire logic                         high_supply_brownout_i,
  input  wire logic                         pin_reset_b_i,
  input  wire logic                         watchdog_req_i,
  input  wire logic                         sys_request_i,
  input  wire logic [rct_pkg::RCT_BKUP_W-1:0] backup_exit_src_i,
  // AHB-Lite slave
  input  wire logic                         hsel_i,
  input  wire logic [31:0]                  haddr_i,
  input  wire logic [1:0]                   htrans_i,
  input  wire logic [2:0]                   hsize_i,
  input  wire logic                         hwrite_i,
  input  wire logic [31:0]                  hwdata_i,
  input  wire logic                         hready_i,
  output logic      [31:0]                  hrdata_o,
  output logic                              hreadyout_o,
  output logic                              hresp_o,
  // domain resets, active low
  output logic                              aon_dom_rst_b_o,
  output logic                              clkgen_rst_b_o,
  output logic                              debug_rst_b_o,
  output logic                              core_rst_b_o,
  // status
  output logic                              reset_active_o,
  output logic      [rct_pkg::RCT_CAUSE_W-1:0] reset_source_record_o,
  output logic      [rct_pkg::RCT_BKUP_W-1:0]  backup_exit_source_o
);
  import rct_pkg::*;

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (HOLD_CYCLES < 1 || HOLD_CYCLES > (2 ** RCT_CNT_W) - 1) begin : g_chk_hold
    $error("rct_reset_cause_tracker: HOLD_CYCLES out of range");
  end

  localparam logic [RCT_CNT_W-1:0] HOLD_LAST = RCT_CNT_W'(HOLD_CYCLES - 1);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  rct_state_t                  state_r;
  rct_state_t                  state_nxt;
  logic [RCT_CAUSE_W-1:0]      cause_r;
  logic [RCT_CAUSE_W-1:0]      cause_nxt;
  logic [RCT_SCOPE_W-1:0]      scope_r;
  logic [RCT_SCOPE_W-1:0]      scope_nxt;
  logic [RCT_BKUP_W-1:0]       bkup_r;
  logic [RCT_BKUP_W-1:0]       bkup_nxt;
  logic [RCT_CNT_W-1:0]        cnt_r;
  logic [RCT_CNT_W-1:0]        cnt_nxt;
  logic                        sw_sysreq_r;
  logic                        sw_sysreq_nxt;
  logic [RCT_SCOPE_W-1:0]      dom_rst_b_r;
  logic                        active_r;

  // ------------------------------------------------------------------
  // bus front end
  // ------------------------------------------------------------------
  wire                         ctrl_wr;
  wire [31:0]                  bus_wdata;

  rct_ahb_slave u_ahb (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hsize_i     (hsize_i),
    .hwrite_i    (hwrite_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .rd_cause_i  (cause_r),
    .rd_bkup_i   (bkup_r),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .ctrl_wr_o   (ctrl_wr),
    .wdata_o     (bus_wdata)
  );

  // software system request: a one-cycle pulse per write of the bit
  assign sw_sysreq_nxt = ctrl_wr & bus_wdata[RCT_CTRL_SYSREQ_BIT];

  // ------------------------------------------------------------------
  // request vector, one bit per cause position
  // ------------------------------------------------------------------
  wire                         bkup_any = |backup_exit_src_i;
  wire [RCT_CAUSE_W-1:0]       req_vec;

  assign req_vec[RCT_BIT_POWER_ON]             = 1'b0;
  assign req_vec[RCT_BIT_CORE_SUPPLY_BROWNOUT] = core_supply_brownout_i;
  assign req_vec[RCT_BIT_HIGH_SUPPLY_BROWNOUT] = high_supply_brownout_i;
  assign req_vec[RCT_BIT_UNUSED]               = 1'b0;
  assign req_vec[RCT_BIT_PIN_RESET_FLAG]       = ~pin_reset_b_i;
  assign req_vec[RCT_BIT_WATCHDOG_FLAG]        = watchdog_req_i;
  assign req_vec[RCT_BIT_SYS_REQUEST_FLAG]     = sys_request_i | sw_sysreq_r;
  assign req_vec[RCT_BIT_BACKUP]               = bkup_any;

  wire                         req_any = |req_vec;
  wire                         in_hold = (state_r == RCT_ST_HOLD);

  // ------------------------------------------------------------------
  // arbitration: during a hold the current cause competes too, so only
  // a higher-priority source can replace it
  // ------------------------------------------------------------------
  wire [RCT_CAUSE_W-1:0]       arb_in = req_vec | (in_hold ? cause_r : RCT_CAUSE_NONE);
  wire [RCT_CAUSE_W-1:0]       grant;

  rct_src_arbiter #(
    .WIDTH (RCT_CAUSE_W)
  ) u_arb (
    .req_i   (arb_in),
    .grant_o (grant)
  );

  wire                         upgrade   = in_hold && (grant != cause_r);
  wire [RCT_SCOPE_W-1:0]       grant_scp = rct_scope_of(grant);
  wire                         hold_done = (cnt_r == HOLD_LAST);

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    scope_nxt = scope_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      RCT_ST_RUN: begin
        if (req_any) begin
          state_nxt = RCT_ST_HOLD;
          cause_nxt = grant;
          scope_nxt = grant_scp;
          cnt_nxt   = '0;
        end
      end
      RCT_ST_HOLD: begin
        if (upgrade) begin
          cause_nxt = grant;
          scope_nxt = scope_r | grant_scp;
          cnt_nxt   = '0;
        end else if (req_any) begin
          cnt_nxt   = '0;
        end else if (hold_done) begin
          state_nxt = RCT_ST_RUN;
          scope_nxt = RCT_SCOPE_NONE;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt   = cnt_r + RCT_CNT_W'(1);
        end
      end
      default: begin
        state_nxt = RCT_ST_HOLD;
        cause_nxt = RCT_CAUSE_RST;
        scope_nxt = RCT_SCOPE_SUPPLY_FULL;
        cnt_nxt   = '0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // backup exit source record: kept only while the cause is backup
  // ------------------------------------------------------------------
  wire                         entering = (state_r == RCT_ST_RUN) && req_any;
  wire [RCT_BKUP_W-1:0]        bkup_base = entering ? RCT_BKUP_RST : bkup_r;

  assign bkup_nxt = cause_nxt[RCT_BIT_BACKUP] ?
                    (bkup_base | backup_exit_src_i) : RCT_BKUP_RST;

  // ------------------------------------------------------------------
  // registers; rst_b_i is the power-on reset of the always-on domain
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= RCT_ST_HOLD;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cause_r <= RCT_CAUSE_RST;
      bkup_r  <= RCT_BKUP_RST;
    end else begin
      cause_r <= cause_nxt;
      bkup_r  <= bkup_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scope_r     <= RCT_SCOPE_SUPPLY_FULL;
      sw_sysreq_r <= 1'b0;
    end else begin
      scope_r     <= scope_nxt;
      sw_sysreq_r <= sw_sysreq_nxt;
    end
  end

  // ------------------------------------------------------------------
  // domain reset outputs follow the next scope so that they assert at
  // the same edge that samples the request
  // ------------------------------------------------------------------
  wire [RCT_SCOPE_W-1:0]       dom_rst_b_nxt = ~scope_nxt;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dom_rst_b_r <= ~RCT_SCOPE_SUPPLY_FULL;
      active_r    <= 1'b1;
    end else begin
      dom_rst_b_r <= dom_rst_b_nxt;
      active_r    <= (state_nxt == RCT_ST_HOLD);
    end
  end

  // always-on group: only power-on and high-supply brown-out
  assign aon_dom_rst_b_o = dom_rst_b_r[RCT_SCP_AON];
  // clock generator with write lock: kept over user resets
  assign clkgen_rst_b_o  = dom_rst_b_r[RCT_SCP_CLKGEN];
  // debug: kept over watchdog and system request
  assign debug_rst_b_o   = dom_rst_b_r[RCT_SCP_DEBUG];
  // everything else, backup exit included
  assign core_rst_b_o    = dom_rst_b_r[RCT_SCP_CORE];

  // ------------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------------
  assign reset_active_o        = active_r;
  assign reset_source_record_o = cause_r;
  assign backup_exit_source_o  = bkup_r;

endmodule

`default_nettype wire

// [common/rct_pkg.sv]
// shared constants and types of the reset cause tracker
`default_nettype none

package rct_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ------------------------------------------------------------------
  localparam logic [31:0] RCT_ADDR_CAUSE = 32'h0000_0000;
  localparam logic [31:0] RCT_ADDR_BKUP  = 32'h0000_0004;
  localparam logic [31:0] RCT_ADDR_CTRL  = 32'h0000_0008;
  localparam logic [31:0] RCT_ADDR_MASK  = 32'h0000_00fc;

  // ------------------------------------------------------------------
  // cause register layout
  // ------------------------------------------------------------------
  localparam int RCT_CAUSE_W                  = 8;
  localparam int RCT_BIT_POWER_ON             = 0;
  localparam int RCT_BIT_CORE_SUPPLY_BROWNOUT = 1;
  localparam int RCT_BIT_HIGH_SUPPLY_BROWNOUT = 2;
  localparam int RCT_BIT_UNUSED               = 3;
  localparam int RCT_BIT_PIN_RESET_FLAG       = 4;
  localparam int RCT_BIT_WATCHDOG_FLAG        = 5;
  localparam int RCT_BIT_SYS_REQUEST_FLAG     = 6;
  localparam int RCT_BIT_BACKUP               = 7;
  localparam logic [7:0] RCT_CAUSE_RST        = 8'h01;
  localparam logic [7:0] RCT_CAUSE_NONE       = 8'h00;

  // arbitration order, highest priority first
  localparam int RCT_NSRC = 7;
  localparam int RCT_PRIO [RCT_NSRC] = '{0, 2, 1, 4, 5, 6, 7};

  // ------------------------------------------------------------------
  // backup exit source layout
  // ------------------------------------------------------------------
  localparam int RCT_BKUP_W          = 3;
  localparam int RCT_BKUP_RTC        = 0;
  localparam int RCT_BKUP_EXT_WAKE   = 1;
  localparam int RCT_BKUP_BATT_SW    = 2;
  localparam logic [2:0] RCT_BKUP_RST = 3'h0;

  // ------------------------------------------------------------------
  // control register layout
  // ------------------------------------------------------------------
  localparam int RCT_CTRL_SYSREQ_BIT = 0;

  // ------------------------------------------------------------------
  // reset scope: one bit per group of domains
  // ------------------------------------------------------------------
  localparam int RCT_SCOPE_W     = 4;
  localparam int RCT_SCP_AON     = 0;
  localparam int RCT_SCP_CLKGEN  = 1;
  localparam int RCT_SCP_DEBUG   = 2;
  localparam int RCT_SCP_CORE    = 3;
  localparam logic [3:0] RCT_SCOPE_SUPPLY_FULL = 4'hf;
  localparam logic [3:0] RCT_SCOPE_CORE_BOD    = 4'he;
  localparam logic [3:0] RCT_SCOPE_PIN         = 4'hc;
  localparam logic [3:0] RCT_SCOPE_USER        = 4'h8;
  localparam logic [3:0] RCT_SCOPE_BACKUP      = 4'he;
  localparam logic [3:0] RCT_SCOPE_NONE        = 4'h0;

  // ------------------------------------------------------------------
  // timing and bus
  // ------------------------------------------------------------------
  localparam int RCT_HOLD_CYCLES_DEF = 16;
  localparam int RCT_CNT_W           = 16;
  localparam int RCT_HTRANS_ACT_BIT  = 1;

  typedef enum logic [1:0] {
    RCT_ST_RUN  = 2'b01,
    RCT_ST_HOLD = 2'b10
  } rct_state_t;

  // scope of domains reset by a one-hot cause
  function automatic logic [3:0] rct_scope_of(input logic [7:0] cause);
    logic [3:0] s;
    s = RCT_SCOPE_NONE;
    if (cause[RCT_BIT_POWER_ON] || cause[RCT_BIT_HIGH_SUPPLY_BROWNOUT]) begin
      s = RCT_SCOPE_SUPPLY_FULL;
    end else if (cause[RCT_BIT_CORE_SUPPLY_BROWNOUT]) begin
      s = RCT_SCOPE_CORE_BOD;
    end else if (cause[RCT_BIT_PIN_RESET_FLAG]) begin
      s = RCT_SCOPE_PIN;
    end else if (cause[RCT_BIT_WATCHDOG_FLAG] || cause[RCT_BIT_SYS_REQUEST_FLAG]) begin
      s = RCT_SCOPE_USER;
    end else if (cause[RCT_BIT_BACKUP]) begin
      s = RCT_SCOPE_BACKUP;
    end
    return s;
  endfunction

endpackage

`default_nettype wire

// [rtl/rct_src_arbiter.sv]
// fixed-priority one-hot selection of reset sources
`default_nettype none

module rct_src_arbiter #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] req_i,
  output logic      [WIDTH-1:0] grant_o
);
  import rct_pkg::*;

  // ------------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------------
  if (WIDTH != rct_pkg::RCT_CAUSE_W) begin : g_chk
    $error("rct_src_arbiter: WIDTH must equal the cause width");
  end

  // ------------------------------------------------------------------
  // priority walk, lowest first so the highest wins
  // ------------------------------------------------------------------
  always_comb begin
    grant_o = '0;
    for (int i = RCT_NSRC - 1; i >= 0; i--) begin
      if (req_i[RCT_PRIO[i]]) begin
        grant_o = '0;
        grant_o[RCT_PRIO[i]] = 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [rtl/rct_ahb_slave.sv]
// AHB-Lite slave front end with zero wait states
`default_nettype none

module rct_ahb_slave (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hwrite_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic [7:0]  rd_cause_i,
  input  wire logic [2:0]  rd_bkup_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             ctrl_wr_o,
  output logic      [31:0] wdata_o
);
  import rct_pkg::*;

  // ------------------------------------------------------------------
  // address phase decode
  // ------------------------------------------------------------------
  wire        addr_ph  = hsel_i & htrans_i[RCT_HTRANS_ACT_BIT] & hready_i;
  wire [31:0] word_adr = haddr_i & RCT_ADDR_MASK;
  wire        hit_cause = (word_adr == RCT_ADDR_CAUSE);
  wire        hit_bkup  = (word_adr == RCT_ADDR_BKUP);
  wire        hit_ctrl  = (word_adr == RCT_ADDR_CTRL);
  wire        size_ok   = (hsize_i == 3'h2);
  wire [31:0] rd_mux    = hit_cause ? {24'h00_0000, rd_cause_i} :
                          hit_bkup  ? {29'h0000_0000, rd_bkup_i} : 32'h0000_0000;

  logic        wr_ctrl_r;
  logic [31:0] hrdata_r;

  // ------------------------------------------------------------------
  // data phase registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ctrl_r <= 1'b0;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_ctrl_r <= addr_ph & hwrite_i & hit_ctrl & size_ok;
      if (addr_ph && !hwrite_i) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  assign hrdata_o  = hrdata_r;
  assign ctrl_wr_o = wr_ctrl_r;
  assign wdata_o   = hwdata_i;

endmodule

`default_nettype wire

// [verification/rct_cause_checker.sv]
// concurrent checks on the reset cause tracker ports
`default_nettype none

module rct_cause_checker #(
  parameter int HOLD_CYCLES = 2
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        core_supply_brownout_i,
  input wire logic        high_supply_brownout_i,
  input wire logic        pin_reset_b_i,
  input wire logic        watchdog_req_i,
  input wire logic        sys_request_i,
  input wire logic [2:0]  backup_exit_src_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        aon_dom_rst_b_o,
  input wire logic        clkgen_rst_b_o,
  input wire logic        debug_rst_b_o,
  input wire logic        core_rst_b_o,
  input wire logic        reset_active_o,
  input wire logic [7:0]  reset_source_record_o
);
  // --------------------------------
  // idle cycles spent in the hold
  // --------------------------------
  logic        req_any;
  logic [15:0] idle_cnt_r;
  logic [15:0] idle_cnt_nxt;

  assign req_any = core_supply_brownout_i | high_supply_brownout_i | ~pin_reset_b_i
                 | watchdog_req_i | sys_request_i | (|backup_exit_src_i);
  assign idle_cnt_nxt = (reset_active_o && !req_any) ? idle_cnt_r + 16'h0001 : 16'h0000;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_cnt_r <= 16'h0000;
    end else begin
      idle_cnt_r <= idle_cnt_nxt;
    end
  end

  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_rd_cause;
    hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i[7:2] == 6'h00
      && !reset_active_o ##1 !reset_active_o;
  endsequence

  sequence s_wdt_alone;
    watchdog_req_i && !reset_active_o && pin_reset_b_i
      && !core_supply_brownout_i && !high_supply_brownout_i;
  endsequence

  a_cause_onehot: assert property ($onehot(reset_source_record_o))
    else $error("cause record not one-hot");
  a_bit3_zero: assert property (reset_source_record_o[3] == 1'b0)
    else $error("cause bit 3 set");
  a_rd_cause: assert property (s_rd_cause |-> hrdata_o == {24'h0, reset_source_record_o})
    else $error("cause read data wrong");
  a_aon_scope: assert property (
    $fell(aon_dom_rst_b_o) |-> reset_source_record_o[0] || reset_source_record_o[2])
    else $error("always-on group reset by wrong cause");
  a_clkgen_kept: assert property (
    $fell(clkgen_rst_b_o) |-> reset_source_record_o[6:4] == 3'h0)
    else $error("clock generator reset by user reset");
  a_debug_kept: assert property (
    $fell(debug_rst_b_o) |-> reset_source_record_o[6:5] == 2'h0)
    else $error("debug reset by watchdog or request");
  a_backup_scope: assert property (
    $rose(reset_active_o) && reset_source_record_o[7]
      |-> !clkgen_rst_b_o && !debug_rst_b_o && !core_rst_b_o && aon_dom_rst_b_o)
    else $error("backup exit scope wrong");
  a_wdt_entry: assert property (
    s_wdt_alone |=> reset_source_record_o == 8'h20 && !core_rst_b_o && debug_rst_b_o)
    else $error("watchdog entry wrong");
  a_release_cnt: assert property (
    $fell(reset_active_o) |-> idle_cnt_r == 16'(HOLD_CYCLES))
    else $error("hold length wrong");
  a_release_all: assert property (
    $fell(reset_active_o)
      |-> aon_dom_rst_b_o && clkgen_rst_b_o && debug_rst_b_o && core_rst_b_o)
    else $error("domain resets not released together");
endmodule

bind rct_reset_cause_tracker rct_cause_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_rct_cause_checker (
  .sys_clk_i              (sys_clk_i),
  .rst_b_i                (rst_b_i),
  .core_supply_brownout_i (core_supply_brownout_i),
  .high_supply_brownout_i (high_supply_brownout_i),
  .pin_reset_b_i          (pin_reset_b_i),
  .watchdog_req_i         (watchdog_req_i),
  .sys_request_i          (sys_request_i),
  .backup_exit_src_i      (backup_exit_src_i),
  .hsel_i                 (hsel_i),
  .haddr_i                (haddr_i),
  .htrans_i               (htrans_i),
  .hwrite_i               (hwrite_i),
  .hready_i               (hready_i),
  .hrdata_o               (hrdata_o),
  .aon_dom_rst_b_o        (aon_dom_rst_b_o),
  .clkgen_rst_b_o         (clkgen_rst_b_o),
  .debug_rst_b_o          (debug_rst_b_o),
  .core_rst_b_o           (core_rst_b_o),
  .reset_active_o         (reset_active_o),
  .reset_source_record_o  (reset_source_record_o)
);

`default_nettype wire

// [verification/rct_reset_cause_tracker_tb.sv]
// self-checking bench for the reset cause tracker
`default_nettype none

module rct_reset_cause_tracker_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rct_pkg::*;

  // --------------------------------
  // signals and expectation tables
  // --------------------------------
  localparam int HC = 2;
  logic        sys_clk_i, rst_b_i, core_supply_brownout_i, high_supply_brownout_i;
  logic        pin_reset_b_i, watchdog_req_i, sys_request_i, hsel_i, hwrite_i;
  logic [2:0]  backup_exit_src_i, hsize_i, backup_exit_source_o;
  logic [1:0]  htrans_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic        hreadyout_o, hresp_o, aon_dom_rst_b_o, clkgen_rst_b_o;
  logic        debug_rst_b_o, core_rst_b_o, reset_active_o;
  logic [7:0]  reset_source_record_o;
  int          num_errors = 0;
  int          n_checks = 0;
  // per source: core bod, high bod, pin, watchdog, request, three backup exits
  logic [7:0]  ec [8] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h40, 8'h80, 8'h80, 8'h80};
  logic [3:0]  ed [8] = '{4'h8, 4'h0, 4'hc, 4'he, 4'he, 4'h8, 4'h8, 4'h8};
  logic [2:0]  eb [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h4};

  rct_reset_cause_tracker #(.HOLD_CYCLES(HC)) u_rct_reset_cause_tracker (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .core_supply_brownout_i(core_supply_brownout_i),
    .high_supply_brownout_i(high_supply_brownout_i),
    .pin_reset_b_i(pin_reset_b_i), .watchdog_req_i(watchdog_req_i),
    .sys_request_i(sys_request_i), .backup_exit_src_i(backup_exit_src_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hsize_i(hsize_i),
    .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .aon_dom_rst_b_o(aon_dom_rst_b_o), .clkgen_rst_b_o(clkgen_rst_b_o),
    .debug_rst_b_o(debug_rst_b_o), .core_rst_b_o(core_rst_b_o),
    .reset_active_o(reset_active_o), .reset_source_record_o(reset_source_record_o),
    .backup_exit_source_o(backup_exit_source_o)
  );

  // --------------------------------
  // tasks
  // --------------------------------
  task automatic final_report();
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // single word transfer, entered just after a rising edge
  task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    hsize_i <= 3'b010;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    rd = hrdata_o;
  endtask

  task automatic drive(input int idx, input logic on);
    case (idx)
      0: core_supply_brownout_i <= on;
      1: high_supply_brownout_i <= on;
      2: pin_reset_b_i <= ~on;
      3: watchdog_req_i <= on;
      4: sys_request_i <= on;
      default: backup_exit_src_i[idx-5] <= on;
    endcase
  endtask

  task automatic pulse(input int idx);
    drive(idx, 1'b1);
    @(posedge sys_clk_i);
    drive(idx, 1'b0);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (reset_active_o !== 1'b0 && k < 100) begin
      @(posedge sys_clk_i);
      k++;
    end
    if (k >= 100) begin
      num_errors++;
    end
    @(posedge sys_clk_i);
  endtask

  function automatic logic [31:0] doms();
    return {28'h0, aon_dom_rst_b_o, clkgen_rst_b_o, debug_rst_b_o, core_rst_b_o};
  endfunction

  // --------------------------------
  // clock, timeout, sequence
  // --------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    int cyc;
    cyc = 0;
    while (cyc < 3000) begin
      @(posedge sys_clk_i);
      cyc++;
    end
    num_errors++;
    final_report();
  end

  initial begin
    logic [31:0] rd;
    int          i;
    {core_supply_brownout_i, high_supply_brownout_i, watchdog_req_i, sys_request_i} = 4'h0;
    {hsel_i, hwrite_i, htrans_i, hsize_i, backup_exit_src_i} = 10'h000;
    {haddr_i, hwdata_i} = 64'h0;
    pin_reset_b_i = 1'b1;
    rst_b_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    wait_idle();
    chk("por_domains", 32'hf, doms());
    bus(RCT_ADDR_CAUSE, 1'b0, 32'h0, rd);
    chk("por_cause", 32'h01, rd);
    bus(RCT_ADDR_CAUSE, 1'b1, 32'hff, rd);
    bus(RCT_ADDR_CAUSE, 1'b0, 32'h0, rd);
    chk("cause_ro", 32'h01, rd);
    bus(32'h40, 1'b0, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("hresp_okay", 32'h0, {31'h0, hresp_o});
    for (i = 0; i < 8; i++) begin
      pulse(i);
      @(negedge sys_clk_i);
      chk("cause_now", {24'h0, ec[i]}, {24'h0, reset_source_record_o});
      chk("scope", {28'h0, ed[i]}, doms());
      chk("exit_port", {29'h0, eb[i]}, {29'h0, backup_exit_source_o});
      repeat (HC - 1) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("held", 32'h1, {31'h0, reset_active_o});
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("released", 32'hf, doms());
      @(posedge sys_clk_i);
      bus(RCT_ADDR_CAUSE, 1'b0, 32'h0, rd);
      chk("cause_read", {24'h0, ec[i]}, rd);
      bus(RCT_ADDR_BKUP, 1'b0, 32'h0, rd);
      chk("exit_source", {29'h0, eb[i]}, rd);
    end
    bus(RCT_ADDR_CTRL, 1'b1, 32'h1, rd);
    repeat (3) @(posedge sys_clk_i);
    wait_idle();
    bus(RCT_ADDR_CAUSE, 1'b0, 32'h0, rd);
    chk("sys_request", 32'h40, rd);
    bus(RCT_ADDR_CTRL, 1'b0, 32'h0, rd);
    chk("ctrl_read", 32'h0, rd);
    pulse(3);
    pulse(2);
    @(negedge sys_clk_i);
    chk("upgrade", 32'h10, {24'h0, reset_source_record_o});
    chk("upgrade_scope", 32'hc, doms());
    chk("exit_cleared", 32'h0, {29'h0, backup_exit_source_o});
    @(posedge sys_clk_i);
    pulse(3);
    @(negedge sys_clk_i);
    chk("lower_kept", 32'h10, {24'h0, reset_source_record_o});
    wait_idle();
    drive(3, 1'b1);
    pulse(0);
    drive(3, 1'b0);
    @(negedge sys_clk_i);
    chk("priority", 32'h02, {24'h0, reset_source_record_o});
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("midrun_dom", 32'h0, doms());
    @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    wait_idle();
    bus(RCT_ADDR_CAUSE, 1'b0, 32'h0, rd);
    chk("midrun_cause", 32'h01, rd);
    final_report();
  end
endmodule

`default_nettype wire
